// ==== logic/ddr_sram_device.sv ====
// burst sram end: split read/write ports, two-word bursts on the link clock
`timescale 1ns/100ps
module ddr_sram_device (
  ddr_link_if.dev lnk,
  output logic    pll_locked,
  output logic    single_clock_mode,
  output logic    impedance_update,
  output logic    impedance_min
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                rd_pend;
    ddr_sram_pkg::addr_t rd_addr;
    logic                fetch_v;
    ddr_sram_pkg::word_t buf0;
    ddr_sram_pkg::word_t buf1;
    logic                sec_pend;
    ddr_sram_pkg::word_t q;
    logic                q_oe;
    logic                wr_pend;
    ddr_sram_pkg::word_t wd0;
    ddr_sram_pkg::bsel_t wb0;
    logic                echo;
    logic                echo_n;
    logic [1:0]          zq_s;
    logic [1:0]          c_s;
    logic [1:0]          cn_s;
    logic [1:0]          pll_s;
    logic                single;
    logic                min_z;
    logic                cal_p;
    logic                locked;
    logic [ddr_sram_pkg::CNT_W-1:0] lock_cnt;
    logic [ddr_sram_pkg::CNT_W-1:0] cal_cnt;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  // ----------------------------------------------------------------
  // storage: low array holds burst word A+0, high array word A+1
  // ----------------------------------------------------------------
  ddr_sram_pkg::word_t mem_lo [2**ddr_sram_pkg::ADDR_W];
  ddr_sram_pkg::word_t mem_hi [2**ddr_sram_pkg::ADDR_W];
  ddr_sram_pkg::word_t rd_lo;
  ddr_sram_pkg::word_t rd_hi;
  logic                mem_we;
  logic                pll_on;

  assign rd_lo  = mem_lo[s_r.rd_addr];
  assign rd_hi  = mem_hi[s_r.rd_addr];
  assign pll_on = s_r.pll_s[1];
  // commit on the Kb rise that closes a write
  assign mem_we = !lnk.rst_l && !lnk.k_phase && s_r.wr_pend;

  // ----------------------------------------------------------------
  // write commit, one lane-merged word per array
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.link_clk)
  begin
    if (mem_we)
    begin
      mem_lo[lnk.addr] <= ddr_sram_pkg::lane_merge(mem_lo[lnk.addr], s_r.wd0,
                                                   s_r.wb0);
      mem_hi[lnk.addr] <= ddr_sram_pkg::lane_merge(mem_hi[lnk.addr], lnk.d,
                                                   lnk.byte_write_select_n);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt       = s_r;
    // pins not tied to the link edges go through two flops
    s_nxt.zq_s  = {s_r.zq_s[0], lnk.impedance_reference};
    s_nxt.c_s   = {s_r.c_s[0], lnk.c_clk};
    s_nxt.cn_s  = {s_r.cn_s[0], lnk.c_clk_n};
    s_nxt.pll_s = {s_r.pll_s[0], lnk.pll_disable_n};
    // echoes follow the edge type, whichever clock pair times the outputs
    s_nxt.echo   = lnk.k_phase;
    s_nxt.echo_n = !lnk.k_phase;
    s_nxt.cal_p  = 1'b0;

    if (lnk.k_phase)
    begin
      // K rise: port selects are only looked at here
      s_nxt.cal_cnt = s_r.cal_cnt + 1'b1;
      if (s_r.cal_cnt == ddr_sram_pkg::CAL_LAST)
      begin
        s_nxt.cal_p = 1'b1;
        s_nxt.min_z = s_r.zq_s[1];
      end
      s_nxt.rd_pend = !lnk.read_port_select_n;
      if (!lnk.read_port_select_n)
        s_nxt.rd_addr = lnk.addr;
      // fetch both words a cycle later so writes of the prior cycle land
      if (s_r.rd_pend)
      begin
        s_nxt.buf0 = rd_lo;
        s_nxt.buf1 = rd_hi;
        s_nxt.fetch_v = pll_on;
      end
      if (s_r.sec_pend)
      begin
        s_nxt.q        = s_r.buf1;
        s_nxt.q_oe     = 1'b1;
        s_nxt.sec_pend = 1'b0;
      end
      else if (s_r.rd_pend && !pll_on)
      begin
        s_nxt.q        = rd_lo;
        s_nxt.q_oe     = 1'b1;
        s_nxt.sec_pend = 1'b1;
      end
      else
        s_nxt.q_oe = 1'b0;
      // write port: deselect still lets an open write finish at Kb
      s_nxt.wr_pend = !lnk.write_port_select_n;
      if (!lnk.write_port_select_n)
      begin
        s_nxt.wd0 = lnk.d;
        s_nxt.wb0 = lnk.byte_write_select_n;
      end
    end
    else
    begin
      // Kb rise: first word in PLL mode, second word without it
      if (s_r.fetch_v)
      begin
        s_nxt.q        = s_r.buf0;
        s_nxt.q_oe     = 1'b1;
        s_nxt.sec_pend = 1'b1;
        s_nxt.fetch_v  = 1'b0;
      end
      else if (s_r.sec_pend)
      begin
        s_nxt.q        = s_r.buf1;
        s_nxt.sec_pend = 1'b0;
      end
      else
        s_nxt.q_oe = 1'b0;
      s_nxt.wr_pend = 1'b0;
    end

    // lock counter runs only while the pll is enabled
    if (!pll_on)
    begin
      s_nxt.lock_cnt = '0;
      s_nxt.locked   = 1'b0;
    end
    else if (!s_r.locked)
    begin
      s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
      s_nxt.locked   = (s_r.lock_cnt == ddr_sram_pkg::LOCK_LAST);
    end

    if (lnk.rst_l)
    begin
      s_nxt        = '0;
      s_nxt.zq_s   = {s_r.zq_s[0], lnk.impedance_reference};
      s_nxt.c_s    = {s_r.c_s[0], lnk.c_clk};
      s_nxt.cn_s   = {s_r.cn_s[0], lnk.c_clk_n};
      s_nxt.pll_s  = {s_r.pll_s[0], lnk.pll_disable_n};
      s_nxt.echo   = lnk.k_phase;
      s_nxt.echo_n = !lnk.k_phase;
      // strap is caught while reset is held and frozen after release
      s_nxt.single = s_r.c_s[1] && s_r.cn_s[1];
    end
  end

  // ----------------------------------------------------------------
  // registers; a stopped link clock simply freezes everything
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.link_clk)
  begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.q_drv             = s_r.q;
  assign lnk.q_oe              = s_r.q_oe;
  assign lnk.echo_timing_out   = s_r.echo;
  assign lnk.echo_timing_out_n = s_r.echo_n;
  assign pll_locked            = s_r.locked;
  assign single_clock_mode     = s_r.single;
  assign impedance_update      = s_r.cal_p;
  assign impedance_min         = s_r.min_z;

  // pll reset on a stalled clock is not modelled: the lock counter only
  // sees link edges, so a stall reads as a pause
endmodule // ddr_sram_device

// ==== logic/ddr_sram_pkg.sv ====
// shared constants, types and helpers for the split-port burst sram link
package ddr_sram_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 19;
  localparam int WORD_W   = 18;
  localparam int BYTE_W   = 9;
  localparam int LANES    = 2;
  localparam int BURST_W  = 36;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int LINK_PERIOD_NS = 32;
  localparam int PLL_LOCK_NS    = 20000;
  // lock wait counted in link rising edges, rounded up
  localparam int LOCK_CYC = (PLL_LOCK_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int CNT_W    = 10;
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);
  localparam int CAL_CYC  = 1024;
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYC - 1);
  // host: clk cycles per link period, reset hold, lock wait
  localparam int CLK_PER_LINK = 2;
  localparam int HCNT_W       = 12;
  localparam logic [HCNT_W-1:0] RST_HOLD = 12'h010;
  localparam logic [HCNT_W-1:0] HOST_LOCK =
    HCNT_W'(LOCK_CYC * CLK_PER_LINK + 32);
  localparam logic W0_ECHO_PLL  = 1'b0;
  localparam logic W0_ECHO_FAST = 1'b1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [WORD_W-1:0]  word_t;
  typedef logic [LANES-1:0]   bsel_t;
  typedef logic [BURST_W-1:0] burst_t;

  // byte-lane merge: a low select replaces that lane, a high one keeps it
  function automatic word_t lane_merge(word_t old_w, word_t new_w, bsel_t sel_n);
    word_t r;
    r = old_w;
    for (int i = 0; i < LANES; i++)
      if (!sel_n[i])
        r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
    return r;
  endfunction
endpackage

// ==== logic/ddr_link_if.sv ====
// pin-level link between the memory controller and the burst sram
`timescale 1ns/100ps
interface ddr_link_if;
  logic                     link_clk;
  logic                     rst_l;
  logic                     k_phase;
  logic                     c_clk;
  logic                     c_clk_n;
  logic                     read_port_select_n;
  logic                     write_port_select_n;
  ddr_sram_pkg::addr_t      addr;
  ddr_sram_pkg::word_t      d;
  ddr_sram_pkg::bsel_t      byte_write_select_n;
  logic                     pll_disable_n;
  logic                     impedance_reference;
  ddr_sram_pkg::word_t      q_drv;
  logic                     q_oe;
  logic                     echo_timing_out;
  logic                     echo_timing_out_n;
  wire ddr_sram_pkg::word_t q;

  // released bus shows the inverse of the last word, so a late sample cannot pass for data
  assign q = q_oe ? q_drv : ~q_drv;

  modport dev (
    input  link_clk, rst_l, k_phase, c_clk, c_clk_n,
    input  read_port_select_n, write_port_select_n, addr, d,
    input  byte_write_select_n, pll_disable_n, impedance_reference,
    output q_drv, q_oe, echo_timing_out, echo_timing_out_n
  );
  modport ctl (
    output link_clk, rst_l, k_phase, c_clk, c_clk_n,
    output read_port_select_n, write_port_select_n, addr, d,
    output byte_write_select_n, pll_disable_n, impedance_reference,
    input  q, q_oe, echo_timing_out
  );
endinterface

// ==== logic/ddr_sram_ctrl.sv ====
// controller end: makes the link clock, issues bursts, gathers read data
`timescale 1ns/100ps
module ddr_sram_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   pll_enable,
  input  wire logic                   single_clock,
  input  wire logic                   min_impedance,
  input  wire logic                   rd_req,
  input  wire ddr_sram_pkg::addr_t    rd_addr,
  input  wire logic                   wr_req,
  input  wire ddr_sram_pkg::addr_t    wr_addr,
  input  wire ddr_sram_pkg::burst_t   wr_data,
  input  wire logic [3:0]             wr_bws_n,
  output logic                        ready,
  output ddr_sram_pkg::burst_t        rd_data,
  output logic                        rd_valid,
  ddr_link_if.ctl                     lnk
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                link;
    logic                kind_k;
    logic                rst_l;
    logic                k_phase;
    logic                c;
    logic                cn;
    logic                sc;
    logic                rps_n;
    logic                wps_n;
    ddr_sram_pkg::addr_t addr;
    ddr_sram_pkg::word_t d;
    ddr_sram_pkg::bsel_t bws_n;
    ddr_sram_pkg::addr_t wa;
    ddr_sram_pkg::word_t dh;
    ddr_sram_pkg::bsel_t bh;
    logic                pll_n;
    logic                zq;
    logic [ddr_sram_pkg::HCNT_W-1:0] cnt;
    logic                locked;
    logic                ready;
    ddr_sram_pkg::word_t q_s1;
    ddr_sram_pkg::word_t q_s2;
    logic [1:0]          oe_s;
    logic [2:0]          ec_s;
    logic                got0;
    ddr_sram_pkg::burst_t rd_data;
    logic                rd_valid;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic take;
    logic w0_lvl;
    take   = 1'b0;
    w0_lvl = s_r.pll_n ? ddr_sram_pkg::W0_ECHO_PLL : ddr_sram_pkg::W0_ECHO_FAST;
    s_nxt  = s_r;
    // divide by two; outside rst the clock never stalls, so the pll never drops lock
    s_nxt.link = !s_r.link;
    if (!s_r.sc)
    begin
      s_nxt.c  = !s_r.link;
      s_nxt.cn = s_r.link;
    end
    // pins change on the falling link edge, a half period before the rise
    if (s_r.link)
    begin
      s_nxt.k_phase = s_r.kind_k;
      s_nxt.kind_k  = !s_r.kind_k;
      if (s_r.kind_k)
      begin
        take        = s_r.ready;
        s_nxt.rps_n = !(take && rd_req);
        s_nxt.wps_n = !(take && wr_req);
        s_nxt.addr  = rd_addr;
        s_nxt.d     = wr_data[17:0];
        s_nxt.bws_n = wr_bws_n[1:0];
        s_nxt.wa    = wr_addr;
        s_nxt.dh    = wr_data[35:18];
        s_nxt.bh    = wr_bws_n[3:2];
      end
      else
      begin
        s_nxt.rps_n = 1'b1;
        s_nxt.wps_n = 1'b1;
        s_nxt.addr  = s_r.wa;
        s_nxt.d     = s_r.dh;
        s_nxt.bws_n = s_r.bh;
      end
    end
    // hold the sram in reset briefly, then, if the pll is enabled, wait out its lock time
    if (!s_r.locked)
    begin
      s_nxt.cnt    = s_r.cnt + 1'b1;
      s_nxt.locked = s_r.pll_n ? (s_r.cnt == ddr_sram_pkg::HOST_LOCK)
                               : (s_r.cnt == ddr_sram_pkg::RST_HOLD);
    end
    // sram reset moves with the other pins on the falling link edge, never with a rise
    if (s_r.link)
      s_nxt.rst_l = (s_r.cnt < ddr_sram_pkg::RST_HOLD);
    s_nxt.ready = s_nxt.locked && s_nxt.link && s_nxt.kind_k;
    // read return: q and echo share the same two-flop delay
    s_nxt.q_s1     = lnk.q;
    s_nxt.q_s2     = s_r.q_s1;
    s_nxt.oe_s     = {s_r.oe_s[0], lnk.q_oe};
    s_nxt.ec_s     = {s_r.ec_s[1:0], lnk.echo_timing_out};
    s_nxt.rd_valid = 1'b0;
    if ((s_r.ec_s[2] != s_r.ec_s[1]) && s_r.oe_s[1])
    begin
      if (s_r.ec_s[1] == w0_lvl)
      begin
        s_nxt.rd_data[17:0] = s_r.q_s2;
        s_nxt.got0          = 1'b1;
      end
      else if (s_r.got0)
      begin
        s_nxt.rd_data[35:18] = s_r.q_s2;
        s_nxt.rd_valid       = 1'b1;
        s_nxt.got0           = 1'b0;
      end
    end
    if (rst)
    begin
      s_nxt       = '0;
      s_nxt.rst_l = 1'b1;
      s_nxt.rps_n = 1'b1;
      s_nxt.wps_n = 1'b1;
      s_nxt.bws_n = '1;
      s_nxt.k_phase = 1'b1;
      s_nxt.kind_k  = 1'b1;
      s_nxt.sc    = single_clock;
      s_nxt.c     = single_clock;
      s_nxt.cn    = 1'b1;
      s_nxt.pll_n = pll_enable;
      s_nxt.zq    = min_impedance;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.link_clk            = s_r.link;
  assign lnk.rst_l               = s_r.rst_l;
  assign lnk.k_phase             = s_r.k_phase;
  assign lnk.c_clk               = s_r.c;
  assign lnk.c_clk_n             = s_r.cn;
  assign lnk.read_port_select_n  = s_r.rps_n;
  assign lnk.write_port_select_n = s_r.wps_n;
  assign lnk.addr                = s_r.addr;
  assign lnk.d                   = s_r.d;
  assign lnk.byte_write_select_n = s_r.bws_n;
  assign lnk.pll_disable_n       = s_r.pll_n;
  assign lnk.impedance_reference = s_r.zq;
  assign ready                   = s_r.ready;
  assign rd_data                 = s_r.rd_data;
  assign rd_valid                = s_r.rd_valid;
endmodule // ddr_sram_ctrl

// ==== test/ddr_link_monitor.sv ====
// concurrent checks on the link between the controller and the burst sram
`timescale 1ns/100ps
module ddr_link_monitor (
  input wire logic link_clk,
  input wire logic rst_l,
  input wire logic k_phase,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic read_port_select_n,
  input wire logic pll_disable_n,
  input wire logic q_oe,
  input wire logic echo_timing_out,
  input wire logic echo_timing_out_n,
  input wire logic impedance_update
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [11:0] rise_cnt_r;
  logic        seen_r;
  wire  logic  rd_take = k_phase & ~read_port_select_n;

  // the first pulse after reset has no reference, so spacing is judged from the second on
  always_ff @(posedge link_clk)
  begin
    if (rst_l)
    begin
      rise_cnt_r <= 12'h000;
      seen_r     <= 1'b0;
    end
    else if (impedance_update)
    begin
      rise_cnt_r <= 12'h000;
      seen_r     <= 1'b1;
    end
    else
      rise_cnt_r <= rise_cnt_r + 12'h001;
  end

  default clocking @(posedge link_clk); endclocking
  default disable iff (rst_l);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence pll_words_s;
    ##4 (q_oe && !echo_timing_out) ##1 (q_oe && echo_timing_out);
  endsequence
  sequence legacy_words_s;
    ##3 (q_oe && echo_timing_out) ##1 (q_oe && !echo_timing_out);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  read_pll_a: assert property (rd_take && pll_disable_n |-> pll_words_s)
    else $error("pll read words not at kb t+1 and k t+2");
  read_legacy_a: assert property (rd_take && !pll_disable_n |-> legacy_words_s)
    else $error("legacy read words not one cycle after the take");
  output_float_a: assert property (q_oe |-> (pll_disable_n ?
    ($past(rd_take, 4) || $past(rd_take, 5)) : ($past(rd_take, 3) || $past(rd_take, 4))))
    else $error("read data driven with no read pending");
  echo_follow_a: assert property (!$past(rst_l) |->
    (echo_timing_out == $past(k_phase)) && (echo_timing_out_n == !echo_timing_out))
    else $error("echo clocks do not follow the input clock phase");
  kphase_toggle_a: assert property (!$past(rst_l) |-> k_phase != $past(k_phase))
    else $error("input clock phase did not alternate");
  strap_fixed_a: assert property ($past(c_clk && c_clk_n) |-> c_clk && c_clk_n)
    else $error("single clock strap changed during operation");
  cal_period_a: assert property (impedance_update && seen_r |-> rise_cnt_r == 12'h7ff)
    else $error("impedance update not 1024 input cycles after the last");
  cal_pulse_a: assert property (impedance_update |=> !impedance_update)
    else $error("impedance update longer than one link cycle");
endmodule // ddr_link_monitor

// ==== test/test_ddr_split_port_sram_interface.sv ====
// self-checking bench: controller end and sram end joined across the link
`timescale 1ns/100ps
module test_ddr_split_port_sram_interface;
  logic                 clk;
  logic                 rst;
  logic                 pll_enable;
  logic                 single_clock;
  logic                 min_impedance;
  logic                 rd_req;
  ddr_sram_pkg::addr_t  rd_addr;
  logic                 wr_req;
  ddr_sram_pkg::addr_t  wr_addr;
  ddr_sram_pkg::burst_t wr_data;
  logic [3:0]           wr_bws_n;
  logic                 ready;
  ddr_sram_pkg::burst_t rd_data;
  logic                 rd_valid;
  logic                 pll_locked;
  logic                 single_clock_mode;
  logic                 impedance_update;
  logic                 impedance_min;
  int                   num_errors;
  int                   n_tests;
  logic [31:0]          seed;
  logic [15:0]          base;
  ddr_sram_pkg::burst_t mem [8];
  ddr_sram_pkg::burst_t exp_q [$];

  ddr_link_if lnk ();

  ddr_sram_device u_ddr_sram_device (
    .lnk               (lnk),
    .pll_locked        (pll_locked),
    .single_clock_mode (single_clock_mode),
    .impedance_update  (impedance_update),
    .impedance_min     (impedance_min)
  );

  ddr_sram_ctrl u_ddr_sram_ctrl (
    .clk           (clk),
    .rst           (rst),
    .pll_enable    (pll_enable),
    .single_clock  (single_clock),
    .min_impedance (min_impedance),
    .rd_req        (rd_req),
    .rd_addr       (rd_addr),
    .wr_req        (wr_req),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_bws_n      (wr_bws_n),
    .ready         (ready),
    .rd_data       (rd_data),
    .rd_valid      (rd_valid),
    .lnk           (lnk)
  );

  ddr_link_monitor u_ddr_link_monitor (
    .link_clk           (lnk.link_clk),
    .rst_l              (lnk.rst_l),
    .k_phase            (lnk.k_phase),
    .c_clk              (lnk.c_clk),
    .c_clk_n            (lnk.c_clk_n),
    .read_port_select_n (lnk.read_port_select_n),
    .pll_disable_n      (lnk.pll_disable_n),
    .q_oe               (lnk.q_oe),
    .echo_timing_out    (lnk.echo_timing_out),
    .echo_timing_out_n  (lnk.echo_timing_out_n),
    .impedance_update   (impedance_update)
  );

  initial
  begin
    clk = 1'b0;
    forever #(ddr_sram_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    logic [31:0] s;
    s = seed;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    seed = s;
    return s;
  endfunction

  function automatic ddr_sram_pkg::burst_t rnd36();
    logic [63:0] v;
    v = {xs(), xs()};
    return v[35:0];
  endfunction

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input ddr_sram_pkg::burst_t exp,
                       input ddr_sram_pkg::burst_t got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // sel low waits for ready, sel high for the impedance update pulse
  task automatic wait_for(input string name, input bit sel, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while ((sel ? impedance_update : ready) !== 1'b1)
    begin
      n++;
      if (n > lim)
      begin
        num_errors++;
        $display("[FAIL] %s expected high seen timeout", name);
        test_done();
      end
      @(negedge clk);
    end
  endtask

  // one request slot; the model applies the write before the read of the same slot
  task automatic slot(input logic rd, input logic wr, input logic [2:0] ri,
                      input logic [2:0] wi, input ddr_sram_pkg::burst_t wd,
                      input logic [3:0] bn);
    wait_for("ready", 1'b0, 16);
    rd_req   = rd;
    rd_addr  = {base, ri};
    wr_req   = wr;
    wr_addr  = {base, wi};
    wr_data  = wd;
    wr_bws_n = bn;
    for (int l = 0; l < 4; l++)
      if (wr && !bn[l])
        mem[wi][l*ddr_sram_pkg::BYTE_W +: 9] = wd[l*ddr_sram_pkg::BYTE_W +: 9];
    if (rd)
      exp_q.push_back(mem[ri]);
    @(negedge clk);
    rd_req = 1'b0;
    wr_req = 1'b0;
  endtask

  // read results come back in order, one pulse per burst
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
      check("rd_data", exp_q.size() > 0 ? exp_q.pop_front() : 'x, rd_data);
  end

  task automatic session(input string name, input logic pe, input logic sc,
                         input logic mi, input int n);
    logic [31:0] r;
    rst           = 1'b1;
    pll_enable    = pe;
    single_clock  = sc;
    min_impedance = mi;
    repeat (8) @(negedge clk);
    rst  = 1'b0;
    r    = xs();
    base = r[15:0];
    wait_for("ready", 1'b0, 3000);
    check("single_clock_mode", 36'(sc), 36'(single_clock_mode));
    check("pll_locked", 36'(pe), 36'(pll_locked));
    for (int k = 0; k < 8; k++)
      slot(1'b0, 1'b1, 3'h0, 3'(k), rnd36(), 4'h0);
    for (int k = 0; k < n; k++)
    begin
      r = xs();
      slot(r[0], r[1], r[4:2], r[7:5], rnd36(), r[11:8]);
    end
    wait_for("impedance_update", 1'b1, 6000);
    repeat (4) @(negedge clk);
    check("impedance_min", 36'(mi), 36'(impedance_min));
    // a second update gives the monitor a spacing to judge
    wait_for("impedance_update", 1'b1, 6000);
    repeat (4) @(negedge clk);
    check("impedance_min again", 36'(mi), 36'(impedance_min));
    for (int k = 0; k < 200 && exp_q.size() > 0; k++)
      @(negedge clk);
    check("reads outstanding", 36'h0, 36'(exp_q.size()));
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors    = 0;
    n_tests       = 0;
    seed          = 32'h00000039;
    base          = 16'h0000;
    rst           = 1'b1;
    pll_enable    = 1'b1;
    single_clock  = 1'b0;
    min_impedance = 1'b0;
    rd_req        = 1'b0;
    rd_addr       = '0;
    wr_req        = 1'b0;
    wr_addr       = '0;
    wr_data       = '0;
    wr_bws_n      = 4'hf;
    session("pll_on", 1'b1, 1'b0, 1'b1, 120);
    session("legacy_single_clock", 1'b0, 1'b1, 1'b0, 120);
    session("legacy", 1'b0, 1'b0, 1'b1, 60);
    test_done();
  end
endmodule // test_ddr_split_port_sram_interface
